// ==== include/iupc_pkg.sv ====
// package: constants and types for the integer pipeline control block
// Functional notes
// - every stage starts on rising clock edge
// - four parallel stages: fetch, decode, execute, write
// - fetch stage drives the instruction address
// - decode latches, decodes, reads operands, next address
// - execute computes, prioritises and takes traps
// - write commits only when no trap taken
// - single-cycle instruction: four cycles, one per cycle
// - multicycle instructions insert internal opcodes into decode
// - opcode counts 1,2,2,3,3,1,1; never more than three
// - jump and trap return: no data bus cycle
// - fetching continues into a two-entry prefetch buffer
// - N bus cycles take N plus three cycles
// - load delays fetch one cycle, store two
// - bypass paths forward register-to-register results
// - stall load consumer until load data ready
// - same stall for call and jump link reads
// - branches resolved in decode, one delay slot
// - annul flag kills the delay-slot instruction
// - external hold inputs freeze the pipeline
// - trap annuls followers; handler executes fourth cycle after
// - interlock opcode pairs with a null bus cycle
package iupc_pkg;
    localparam logic [31:0] RESET_PC    = 32'h0000_0000;
    localparam logic [31:0] INSN_BYTES  = 32'h0000_0004;
    localparam logic [4:0]  LINK_REG    = 5'h0F;
    localparam logic [4:0]  ZERO_REG    = 5'h00;
    localparam int          F_OP        = 30;
    localparam int          F_ANNUL     = 29;
    localparam int          F_RD        = 25;
    localparam int          F_COND      = 25;
    localparam int          F_OP2       = 22;
    localparam int          F_OP3       = 19;
    localparam int          F_RS1       = 14;
    localparam int          F_IMM       = 13;
    localparam int          F_RS2       = 0;
    localparam int          W_DISP22    = 22;
    localparam int          W_DISP30    = 30;
    localparam int          M_STORE_BIT = 2;
    localparam logic [1:0]  OP_BRANCH   = 2'h0;
    localparam logic [1:0]  OP_CALL     = 2'h1;
    localparam logic [1:0]  OP_ALU      = 2'h2;
    localparam logic [1:0]  OP_MEM      = 2'h3;
    localparam logic [2:0]  OP2_BCC     = 3'h2;
    localparam logic [5:0]  OP3_JUMP    = 6'h38;
    localparam logic [5:0]  OP3_TRET    = 6'h39;
    localparam logic [3:0]  M_LDD       = 4'h3;
    localparam logic [3:0]  M_STD       = 4'h7;
    localparam logic [3:0]  M_LDSTUB    = 4'hD;
    localparam logic [3:0]  M_SWAP      = 4'hF;
    localparam logic [1:0]  IOP_NONE    = 2'h0;
    localparam logic [1:0]  IOP_LD      = 2'h1;
    localparam logic [1:0]  IOP_LDD     = 2'h2;
    localparam logic [1:0]  IOP_ST      = 2'h2;
    localparam logic [1:0]  IOP_STD     = 2'h3;
    localparam logic [1:0]  IOP_ATOM    = 2'h3;
    localparam logic [1:0]  IOP_JUMP    = 2'h1;
    localparam logic [1:0]  IOP_TRET    = 2'h1;
    localparam logic [1:0]  BYP_RF      = 2'h0;
    localparam logic [1:0]  BYP_WB      = 2'h1;
    localparam logic [1:0]  BYP_DONE    = 2'h2;
    localparam int          CC_N        = 3;
    localparam int          CC_Z        = 2;
    localparam int          CC_V        = 1;
    localparam int          CC_C        = 0;

    typedef enum logic [3:0] {
        CLS_ALU, CLS_IMM, CLS_BRANCH, CLS_CALL, CLS_LD, CLS_LDD,
        CLS_ST, CLS_STD, CLS_ATOM, CLS_JUMP, CLS_TRET
    } iupc_cls_t;

    typedef enum logic [1:0] {BUS_FETCH, BUS_DATA, BUS_NULL} iupc_bus_t;

    typedef struct packed {
        logic [1:0] memory_hold_inputs;
        logic       bus_arbitration_hold;
    } iupc_hold_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic [31:0] word;
    } iupc_fw_t;

    typedef struct packed {
        logic        valid;
        logic        internal_opcode;
        logic        late;
        logic        wr;
        logic [1:0]  iop_left;
        iupc_cls_t   cls;
        logic [4:0]  rd;
        logic [31:0] pc;
        logic [31:0] word;
    } iupc_stage_t;

    typedef struct packed {
        iupc_hold_t        hs1;
        iupc_hold_t        hs2;
        logic              frz;
        iupc_fw_t [1:0]    pfb;
        iupc_stage_t       dec;
        iupc_stage_t       ex;
        iupc_stage_t       wb;
        logic [31:0]       fa;
        iupc_bus_t         slot;
        logic              pend;
        logic [31:0]       pend_tgt;
        logic              annul;
        logic              trap_wait;
        logic              trap_out;
        logic              ilk;
        logic              commit;
        logic [1:0]        byp1;
        logic [1:0]        byp2;
    } iupc_state_t;
endpackage : iupc_pkg

// ==== rtl/iupc_pipeline_control.sv ====
// module: four-stage integer pipeline control
`timescale 1ns/10ps
`default_nettype none
module iupc_pipeline_control (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [31:0]           fetch_word,
    input  wire logic [3:0]            cc_flags,
    input  wire logic [31:0]           indirect_target,
    input  wire logic                  trap_req,
    input  wire logic [31:0]           trap_vector,
    input  wire iupc_pkg::iupc_hold_t  hold_in,
    output logic [31:0]                fetch_addr,
    output var iupc_pkg::iupc_bus_t    bus_slot,
    output var iupc_pkg::iupc_stage_t  dec_stage,
    output var iupc_pkg::iupc_stage_t  ex_stage,
    output var iupc_pkg::iupc_stage_t  wb_stage,
    output logic                       wb_commit,
    output logic [1:0]                 byp_rs1,
    output logic [1:0]                 byp_rs2,
    output logic                       interlock,
    output logic                       trap_taken,
    output logic                       pipe_frozen
);
    function automatic iupc_pkg::iupc_state_t rst_state();
        rst_state    = '0;
        rst_state.fa = iupc_pkg::RESET_PC;
    endfunction : rst_state

    localparam iupc_pkg::iupc_state_t RST_STATE = rst_state();

    function automatic iupc_pkg::iupc_cls_t classify(input logic [31:0] w);
        logic [5:0] op3;
        op3      = w[iupc_pkg::F_OP3 +: 6];
        classify = iupc_pkg::CLS_ALU;
        case (w[iupc_pkg::F_OP +: 2])
            iupc_pkg::OP_BRANCH: begin
                if (w[iupc_pkg::F_OP2 +: 3] == iupc_pkg::OP2_BCC)
                    classify = iupc_pkg::CLS_BRANCH;
                else
                    classify = iupc_pkg::CLS_IMM;
            end
            iupc_pkg::OP_CALL: classify = iupc_pkg::CLS_CALL;
            iupc_pkg::OP_ALU: begin
                if (op3 == iupc_pkg::OP3_JUMP)
                    classify = iupc_pkg::CLS_JUMP;
                else if (op3 == iupc_pkg::OP3_TRET)
                    classify = iupc_pkg::CLS_TRET;
            end
            iupc_pkg::OP_MEM: begin
                case (op3[3:0])
                    iupc_pkg::M_LDD: classify = iupc_pkg::CLS_LDD;
                    iupc_pkg::M_STD: classify = iupc_pkg::CLS_STD;
                    iupc_pkg::M_LDSTUB,
                    iupc_pkg::M_SWAP: classify = iupc_pkg::CLS_ATOM;
                    default: begin
                        if (op3[iupc_pkg::M_STORE_BIT])
                            classify = iupc_pkg::CLS_ST;
                        else
                            classify = iupc_pkg::CLS_LD;
                    end
                endcase
            end
            default: classify = iupc_pkg::CLS_ALU;
        endcase
    endfunction : classify

    // internal opcodes inserted behind each multicycle instruction class
    function automatic logic [1:0] iop_count(input iupc_pkg::iupc_cls_t c);
        case (c)
            iupc_pkg::CLS_LD:   iop_count = iupc_pkg::IOP_LD;
            iupc_pkg::CLS_LDD:  iop_count = iupc_pkg::IOP_LDD;
            iupc_pkg::CLS_ST:   iop_count = iupc_pkg::IOP_ST;
            iupc_pkg::CLS_STD:  iop_count = iupc_pkg::IOP_STD;
            iupc_pkg::CLS_ATOM: iop_count = iupc_pkg::IOP_ATOM;
            iupc_pkg::CLS_JUMP: iop_count = iupc_pkg::IOP_JUMP;
            iupc_pkg::CLS_TRET: iop_count = iupc_pkg::IOP_TRET;
            default:            iop_count = iupc_pkg::IOP_NONE;
        endcase
    endfunction : iop_count

    function automatic logic is_mem(input iupc_pkg::iupc_cls_t c);
        is_mem = c inside {iupc_pkg::CLS_LD, iupc_pkg::CLS_LDD, iupc_pkg::CLS_ST,
                           iupc_pkg::CLS_STD, iupc_pkg::CLS_ATOM};
    endfunction : is_mem

    function automatic logic reads_regs(input iupc_pkg::iupc_cls_t c);
        reads_regs = !(c inside {iupc_pkg::CLS_BRANCH, iupc_pkg::CLS_CALL, iupc_pkg::CLS_IMM});
    endfunction : reads_regs

    // condition code test of a conditional branch
    function automatic logic cond_true(input logic [31:0] w, input logic [3:0] f);
        logic b;
        logic nv;
        nv = f[iupc_pkg::CC_N] ^ f[iupc_pkg::CC_V];
        case (w[iupc_pkg::F_COND +: 3])
            3'h1:    b = f[iupc_pkg::CC_Z];
            3'h2:    b = f[iupc_pkg::CC_Z] | nv;
            3'h3:    b = nv;
            3'h4:    b = f[iupc_pkg::CC_C] | f[iupc_pkg::CC_Z];
            3'h5:    b = f[iupc_pkg::CC_C];
            3'h6:    b = f[iupc_pkg::CC_N];
            3'h7:    b = f[iupc_pkg::CC_V];
            default: b = 1'b0;
        endcase
        cond_true = w[iupc_pkg::F_COND + 3] ^ b;
    endfunction : cond_true

    function automatic iupc_pkg::iupc_stage_t enter(input iupc_pkg::iupc_fw_t f);
        iupc_pkg::iupc_cls_t c;
        c              = classify(f.word);
        enter          = '0;
        enter.valid    = f.valid;
        enter.pc       = f.pc;
        enter.word     = f.word;
        enter.cls      = c;
        enter.iop_left = iop_count(c);
        enter.late     = c inside {iupc_pkg::CLS_LD, iupc_pkg::CLS_LDD, iupc_pkg::CLS_ATOM,
                                   iupc_pkg::CLS_CALL, iupc_pkg::CLS_JUMP};
        enter.wr       = c inside {iupc_pkg::CLS_ALU, iupc_pkg::CLS_IMM,
                                   iupc_pkg::CLS_CALL, iupc_pkg::CLS_JUMP};
        enter.rd       = (c == iupc_pkg::CLS_CALL) ? iupc_pkg::LINK_REG : f.word[iupc_pkg::F_RD +: 5];
    endfunction : enter

    function automatic logic [1:0] byp_sel(input logic [4:0] rs, input iupc_pkg::iupc_stage_t e,
                                           input iupc_pkg::iupc_stage_t w);
        byp_sel = iupc_pkg::BYP_RF;
        if (rs == iupc_pkg::ZERO_REG)
            byp_sel = iupc_pkg::BYP_RF;
        else if (e.valid && e.wr && e.rd == rs)
            byp_sel = iupc_pkg::BYP_WB;
        else if (w.valid && w.wr && w.rd == rs)
            byp_sel = iupc_pkg::BYP_DONE;
    endfunction : byp_sel

    logic [1:0]            rst_sync_reg;
    logic                  rst_core_n;
    iupc_pkg::iupc_state_t s_reg;
    iupc_pkg::iupc_state_t s_next;
    iupc_pkg::iupc_fw_t    inc;
    iupc_pkg::iupc_fw_t    p0;
    iupc_pkg::iupc_fw_t    p1;
    iupc_pkg::iupc_fw_t    pi;
    iupc_pkg::iupc_fw_t    q0;
    iupc_pkg::iupc_fw_t    q1;
    iupc_pkg::iupc_fw_t    q2;
    logic                  trap;
    logic                  ilk;
    logic                  redir;
    logic                  ann_now;
    logic                  dec_free;
    logic [31:0]           tgt;
    logic [31:0]           keep_pc;
    logic [4:0]            rs1;
    logic [4:0]            rs2;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_core_n = rst_sync_reg[1];

    always_comb begin
        s_next   = s_reg;
        inc      = '0;
        p0       = '0;
        p1       = '0;
        pi       = '0;
        q0       = '0;
        q1       = '0;
        q2       = '0;
        trap     = 1'b0;
        ilk      = 1'b0;
        redir    = 1'b0;
        ann_now  = 1'b0;
        dec_free = 1'b0;
        tgt      = s_reg.fa;
        keep_pc  = s_reg.fa;
        rs1      = s_reg.dec.word[iupc_pkg::F_RS1 +: 5];
        rs2      = s_reg.dec.word[iupc_pkg::F_RS2 +: 5];
        s_next.hs1 = hold_in;
        s_next.hs2 = s_reg.hs1;
        s_next.frz = |s_reg.hs2;
        if (!s_reg.frz) begin
            inc.valid = (s_reg.slot == iupc_pkg::BUS_FETCH);
            inc.pc    = s_reg.fa;
            inc.word  = fetch_word;
            trap      = trap_req && s_reg.ex.valid && !s_reg.ex.internal_opcode;
            // write stage
            s_next.wb       = s_reg.ex;
            s_next.commit   = s_reg.ex.valid && s_reg.ex.wr && !trap;
            s_next.trap_out = trap;
            // late result still owed by the instruction in execute
            ilk = s_reg.dec.valid && !s_reg.dec.internal_opcode && reads_regs(s_reg.dec.cls)
                  && s_reg.ex.valid && s_reg.ex.late && s_reg.ex.rd != iupc_pkg::ZERO_REG
                  && (s_reg.ex.rd == rs1
                      || (!s_reg.dec.word[iupc_pkg::F_IMM] && s_reg.ex.rd == rs2));
            s_next.ilk = ilk;
            // control transfer resolved in decode
            if (s_reg.dec.valid && !s_reg.dec.internal_opcode) begin
                if (s_reg.dec.cls == iupc_pkg::CLS_CALL) begin
                    redir   = 1'b1;
                    tgt     = s_reg.dec.pc + {s_reg.dec.word[iupc_pkg::W_DISP30-1:0], 2'b00};
                    keep_pc = s_reg.dec.pc + iupc_pkg::INSN_BYTES;
                end else if (s_reg.dec.cls == iupc_pkg::CLS_BRANCH) begin
                    redir   = cond_true(s_reg.dec.word, cc_flags);
                    tgt     = s_reg.dec.pc + {{8{s_reg.dec.word[iupc_pkg::W_DISP22-1]}},
                                              s_reg.dec.word[iupc_pkg::W_DISP22-1:0], 2'b00};
                    keep_pc = s_reg.dec.pc + iupc_pkg::INSN_BYTES;
                    ann_now = s_reg.dec.word[iupc_pkg::F_ANNUL];
                end
            end
            // indirect transfer resolved in execute
            if (s_reg.ex.valid && !s_reg.ex.internal_opcode
                && s_reg.ex.cls inside {iupc_pkg::CLS_JUMP, iupc_pkg::CLS_TRET}) begin
                redir   = 1'b1;
                tgt     = indirect_target;
                keep_pc = s_reg.ex.pc + iupc_pkg::INSN_BYTES;
            end
            ann_now = ann_now || s_reg.annul;
            // execute stage
            s_next.ex   = s_reg.dec;
            s_next.byp1 = byp_sel(rs1, s_reg.ex, s_reg.wb);
            s_next.byp2 = s_reg.dec.word[iupc_pkg::F_IMM] ? iupc_pkg::BYP_RF
                        : byp_sel(rs2, s_reg.ex, s_reg.wb);
            if (ilk) begin
                // interlock opcode occupies the slot instead
                s_next.ex       = s_reg.dec;
                s_next.ex.internal_opcode   = 1'b1;
                s_next.ex.wr    = 1'b0;
                s_next.ex.late  = 1'b0;
                s_next.ex.iop_left = iupc_pkg::IOP_NONE;
                s_next.byp1     = iupc_pkg::BYP_RF;
                s_next.byp2     = iupc_pkg::BYP_RF;
            end
            // words past the delay slot are discarded on a transfer
            p0       = s_reg.pfb[0];
            p1       = s_reg.pfb[1];
            pi       = inc;
            p0.valid = p0.valid && (!redir || p0.pc == keep_pc);
            p1.valid = p1.valid && (!redir || p1.pc == keep_pc);
            pi.valid = pi.valid && (!redir || pi.pc == keep_pc);
            q0 = p0.valid ? p0 : (p1.valid ? p1 : pi);
            q1 = p0.valid ? (p1.valid ? p1 : pi) : (p1.valid ? pi : '0);
            q2 = (p0.valid && p1.valid) ? pi : '0;
            // decode stage
            dec_free = !ilk && !(s_reg.dec.valid && s_reg.dec.iop_left != iupc_pkg::IOP_NONE);
            if (ilk) begin
                s_next.dec    = s_reg.dec;
                s_next.pfb[0] = q0;
                s_next.pfb[1] = q1;
            end else if (!dec_free) begin
                s_next.dec          = s_reg.dec;
                s_next.dec.internal_opcode      = 1'b1;
                s_next.dec.iop_left = s_reg.dec.iop_left - 2'h1;
                s_next.dec.wr       = (s_reg.dec.iop_left == 2'h1)
                                    && s_reg.dec.cls inside {iupc_pkg::CLS_LD, iupc_pkg::CLS_LDD,
                                                             iupc_pkg::CLS_ATOM};
                s_next.pfb[0]       = q0;
                s_next.pfb[1]       = q1;
            end else begin
                s_next.dec    = enter(q0);
                s_next.pfb[0] = q1;
                s_next.pfb[1] = q2;
                if (ann_now && q0.valid) begin
                    s_next.dec.valid = 1'b0;
                    s_next.annul     = 1'b0;
                end else begin
                    s_next.annul = ann_now;
                end
            end
            // next fetch address
            if (s_reg.slot == iupc_pkg::BUS_FETCH) begin
                s_next.fa   = s_reg.pend ? s_reg.pend_tgt : s_reg.fa + iupc_pkg::INSN_BYTES;
                s_next.pend = 1'b0;
            end
            if (redir) begin
                if (s_reg.fa == keep_pc && s_reg.slot != iupc_pkg::BUS_FETCH) begin
                    // delay slot not fetched yet
                    s_next.pend     = 1'b1;
                    s_next.pend_tgt = tgt;
                end else begin
                    s_next.fa = tgt;
                end
            end
            // bus use of the next cycle
            if (s_reg.trap_wait) begin
                s_next.slot      = iupc_pkg::BUS_FETCH;
                s_next.trap_wait = 1'b0;
            end else if (s_next.dec.valid && s_next.dec.internal_opcode && is_mem(s_next.dec.cls)) begin
                s_next.slot = iupc_pkg::BUS_DATA;
            end else if (s_next.dec.valid && s_next.dec.internal_opcode) begin
                s_next.slot = iupc_pkg::BUS_NULL;
            end else if (ilk) begin
                s_next.slot = iupc_pkg::BUS_NULL;
            end else if (s_next.pfb[1].valid
                         || (s_next.pfb[0].valid && s_next.dec.valid
                             && s_next.dec.iop_left != iupc_pkg::IOP_NONE)) begin
                s_next.slot = iupc_pkg::BUS_NULL;
            end else begin
                s_next.slot = iupc_pkg::BUS_FETCH;
            end
            if (trap) begin
                // everything behind the trapping instruction dies
                s_next.ex        = '0;
                s_next.dec       = '0;
                s_next.pfb       = '0;
                s_next.annul     = 1'b0;
                s_next.pend      = 1'b0;
                s_next.ilk       = 1'b0;
                s_next.fa        = trap_vector;
                s_next.slot      = iupc_pkg::BUS_NULL;
                s_next.trap_wait = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n)
            s_reg <= RST_STATE;
        else
            s_reg <= s_next;
    end

    assign fetch_addr  = s_reg.fa;
    assign bus_slot    = s_reg.slot;
    assign dec_stage   = s_reg.dec;
    assign ex_stage    = s_reg.ex;
    assign wb_stage    = s_reg.wb;
    assign wb_commit   = s_reg.commit;
    assign byp_rs1     = s_reg.byp1;
    assign byp_rs2     = s_reg.byp2;
    assign interlock   = s_reg.ilk;
    assign trap_taken  = s_reg.trap_out;
    assign pipe_frozen = s_reg.frz;
endmodule : iupc_pipeline_control
`default_nettype wire

// ==== testbench/iupc_checker_props.sv ====
// checker: port-level timing properties of the pipeline control
`timescale 1ns/10ps
`default_nettype none
module iupc_checker (
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic                  trap_req,
    input wire logic [31:0]           trap_vector,
    input wire iupc_pkg::iupc_hold_t  hold_in,
    input wire logic [31:0]           fetch_addr,
    input wire iupc_pkg::iupc_bus_t   bus_slot,
    input wire iupc_pkg::iupc_stage_t dec_stage,
    input wire iupc_pkg::iupc_stage_t ex_stage,
    input wire iupc_pkg::iupc_stage_t wb_stage,
    input wire logic                  wb_commit,
    input wire logic                  interlock,
    input wire logic                  trap_taken,
    input wire logic                  pipe_frozen
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire hold_any = |hold_in;
    wire ex_real  = ex_stage.valid && !ex_stage.internal_opcode;
    freeze_stand_a: assert property (pipe_frozen ##1 pipe_frozen |-> $stable(fetch_addr) &&
        $stable(dec_stage) && $stable(ex_stage) && $stable(wb_stage)) else $error("frozen stage moved");
    freeze_entry_a: assert property (hold_any [*3] |=> pipe_frozen) else $error("hold not obeyed");
    freeze_exit_a: assert property (!hold_any [*3] |=> !pipe_frozen) else $error("freeze stuck");
    trap_flush_a: assert property (trap_req && ex_real && !pipe_frozen |=> trap_taken && !wb_commit &&
        bus_slot == iupc_pkg::BUS_NULL && fetch_addr == $past(trap_vector) && !ex_stage.valid && !dec_stage.valid)
        else $error("trap flush wrong");
    handler_fourth_a: assert property (trap_taken && !pipe_frozen ##1 !pipe_frozen ##1 !pipe_frozen
        |=> ex_real && ex_stage.pc == $past(fetch_addr, 3)) else $error("handler late");
    iop_insert_a: assert property (ex_real && ex_stage.cls >= iupc_pkg::CLS_LD
        |-> dec_stage.valid && dec_stage.internal_opcode) else $error("no internal opcode");
    null_pair_a: assert property (interlock |-> bus_slot == iupc_pkg::BUS_NULL && ex_stage.internal_opcode)
        else $error("interlock without null cycle");
    load_bus_a: assert property (ex_real && ex_stage.cls == iupc_pkg::CLS_LD
        |-> bus_slot == iupc_pkg::BUS_DATA) else $error("load data cycle missing");
    store_bus_a: assert property (ex_real && ex_stage.cls == iupc_pkg::CLS_ST && !trap_req
        |-> bus_slot == iupc_pkg::BUS_DATA [*2]) else $error("store data cycles wrong");
    cover property (trap_taken);
    cover property (pipe_frozen);
    cover property (interlock);
endmodule : iupc_checker
bind iupc_pipeline_control iupc_checker i_iupc_checker (.clk_sys, .rst_n, .trap_req, .trap_vector, .hold_in,
    .fetch_addr, .bus_slot, .dec_stage, .ex_stage, .wb_stage, .wb_commit, .interlock, .trap_taken, .pipe_frozen);
`default_nettype wire

// ==== testbench/iupc_mem_model.sv ====
// partner: instruction memory and hold-generating bus logic
`timescale 1ns/10ps
`default_nettype none
module iupc_mem_model (
    input  wire logic                 clk_sys,
    input  wire logic [31:0]          fetch_addr,
    input  wire iupc_pkg::iupc_bus_t  bus_slot,
    input  wire logic [2:0]           hold_req,
    output var iupc_pkg::iupc_hold_t  hold_in,
    output logic [31:0]               fetch_word
);
    logic [31:0] mem [0:127];
    initial begin
        hold_in    = '0;
        fetch_word = 32'h0;
    end
    always @(negedge clk_sys) begin
        hold_in <= iupc_pkg::iupc_hold_t'(hold_req);
        // non-fetch cycles: bus not driven, data keeps toggling
        if (bus_slot == iupc_pkg::BUS_FETCH) fetch_word <= mem[fetch_addr[8:2]];
        else fetch_word <= ~fetch_word;
    end
endmodule : iupc_mem_model
`default_nettype wire

// ==== testbench/test_integer_unit_pipeline_control.sv ====
// testbench: program run through the pipeline control with a memory model
`timescale 1ns/10ps
`default_nettype none
module test_integer_unit_pipeline_control;
    typedef struct packed {logic [31:0] pc; logic c; logic [4:0] b;} iupc_note_t;
    localparam logic [31:0] TRAP_PC = 32'h64;
    localparam logic [31:0] VEC     = 32'h100;
    logic                  clk_sys = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  trap_req = 1'b0;
    logic [3:0]            cc_flags = 4'h0;
    logic [2:0]            hold_req = 3'h0;
    logic [31:0]           indirect_target = 32'h0;
    logic [31:0]           lf = 32'h0001243E;
    logic [31:0]           fetch_word, fetch_addr;
    logic [1:0]            byp_rs1, byp_rs2;
    logic                  wb_commit, interlock, trap_taken, pipe_frozen;
    iupc_pkg::iupc_hold_t  hold_in;
    iupc_pkg::iupc_bus_t   bus_slot;
    iupc_pkg::iupc_stage_t dec_stage, ex_stage, wb_stage;
    iupc_note_t            q[$];
    iupc_note_t            e;
    logic [3:0]            bx = 4'h0;
    int                    mismatches = 0, checks = 0, n = 0, ilk = 0;
    always #4 clk_sys = ~clk_sys;
    iupc_pipeline_control i_iupc_pipeline_control (.clk_sys, .rst_n, .fetch_word, .cc_flags, .indirect_target,
        .trap_req, .trap_vector(VEC), .hold_in, .fetch_addr, .bus_slot, .dec_stage, .ex_stage, .wb_stage,
        .wb_commit, .byp_rs1, .byp_rs2, .interlock, .trap_taken, .pipe_frozen);
    iupc_mem_model i_iupc_mem_model (.clk_sys, .fetch_addr, .bus_slot, .hold_req, .hold_in, .fetch_word);
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'hA3000000 : x >> 1;
    endfunction : nxt
    function automatic logic [31:0] alu(input logic [4:0] rs1);
        lf = nxt(lf);
        return {2'h2, 5'(lf[3:0] % 14 + 1), 1'b0, lf[8:4], rs1, 14'h0};
    endfunction : alu
    // b: check flag, then expected bypass selects of rs1 and rs2 in execute
    task automatic put(input logic [31:0] w, input logic c, input logic x = 1'b1, input logic [4:0] b = 5'h0);
        i_iupc_mem_model.mem[n] = w;
        if (x) q.push_back('{pc: 32'(n * 4), c: c, b: b});
        n++;
    endtask : put
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    // datapath side: flags, indirect targets, one trap on a fixed address
    always @(negedge clk_sys) begin
        cc_flags        <= lf[3:0];
        lf              <= nxt(lf);
        indirect_target <= ex_stage.pc + 32'h8;
        trap_req        <= ex_stage.valid && !ex_stage.internal_opcode && ex_stage.pc == TRAP_PC;
    end
    always @(negedge clk_sys) begin
        if (pipe_frozen === 1'b0 && interlock === 1'b1) ilk++;
        if (pipe_frozen === 1'b0 && wb_stage.valid === 1'b1 && wb_stage.internal_opcode === 1'b0 && q.size() > 0) begin
            e = q.pop_front();
            checks++;
            if (wb_stage.pc !== e.pc || wb_commit !== e.c) begin
                mismatches++;
                $display("BAD wb pc/commit expected %h/%b seen %h/%b", e.pc, e.c, wb_stage.pc, wb_commit);
            end
            if (e.b[4] && bx !== e.b[3:0]) begin
                mismatches++;
                $display("BAD bypass expected %h seen %h", e.b[3:0], bx);
            end
        end
        // bypass selects of the instruction now in execute, judged once it reaches write
        if (pipe_frozen === 1'b0) bx = {byp_rs1, byp_rs2};
    end
    initial begin
        for (int k = 0; k < 128; k++) i_iupc_mem_model.mem[k] = alu(5'h0);
        put({2'h2, 5'h09, 6'h00, 19'h0}, 1'b1, 1'b1, 5'h10);
        put({2'h2, 5'h0A, 6'h00, 5'h09, 9'h0, 5'h09}, 1'b1, 1'b1, 5'h15);
        put(alu(5'h09), 1'b1, 1'b1, 5'h18);
        put(alu(5'h0), 1'b1);
        put({2'h3, 5'h05, 6'h00, 19'h0}, 1'b0);
        put(alu(5'h05), 1'b1, 1'b1, 5'h18);
        put({2'h3, 5'h02, 6'h03, 19'h0}, 1'b0);
        put({2'h3, 5'h01, 6'h04, 19'h0}, 1'b0);
        put({2'h3, 5'h01, 6'h07, 19'h0}, 1'b0);
        put({2'h3, 5'h03, 6'h0D, 19'h0}, 1'b0);
        put({2'h1, 30'h2}, 1'b1);
        put(alu(5'h0F), 1'b1, 1'b1, 5'h18);
        put(alu(5'h0), 1'b1);
        put({2'h2, 5'h07, 6'h38, 19'h0}, 1'b1);
        put(alu(5'h07), 1'b1);
        put(alu(5'h0), 1'b1);
        put({2'h2, 5'h00, 6'h39, 19'h0}, 1'b0);
        repeat (2) put(alu(5'h0), 1'b1);
        put({2'h0, 1'b1, 4'h8, 3'h2, 22'h2}, 1'b0);
        put(alu(5'h0), 1'b1, 1'b0);
        put(alu(5'h0), 1'b1);
        put({2'h0, 1'b0, 4'h1, 3'h2, 22'h2}, 1'b0);
        repeat (2) put(alu(5'h0), 1'b1);
        put(alu(5'h0), 1'b0);
        repeat (2) put(alu(5'h0), 1'b1, 1'b0);
        n = 64;
        repeat (4) put(alu(5'h0), 1'b1);
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int k = 0; k < 3; k++) begin
            repeat (12) @(negedge clk_sys);
            hold_req = 3'h1 << k;
            repeat (6) @(negedge clk_sys);
            hold_req = 3'h0;
        end
        $display("test hold done");
        for (int k = 0; k < 400 && q.size() > 0; k++) @(negedge clk_sys);
        $display("test program done");
        checks++;
        if (q.size() != 0 || ilk != 3) begin
            mismatches++;
            $display("BAD left/interlocks expected 0/3 seen %0d/%0d", q.size(), ilk);
        end
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        $display("BAD watchdog expected end seen hang");
        final_report();
    end
endmodule : test_integer_unit_pipeline_control
`default_nettype wire
